/* hdl/tsrm_consts.svh */
`ifndef TSRM_CONSTS_SVH
`define TSRM_CONSTS_SVH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define TSRM_ADDR_LOCAL_TEMP      8'h00
`define TSRM_ADDR_RMT_S_HI        8'h01
`define TSRM_ADDR_ALERT_FLAGS     8'h02
`define TSRM_ADDR_CONFIG          8'h03
`define TSRM_ADDR_CONV_RATE       8'h04
`define TSRM_ADDR_LOCAL_HIGH      8'h05
`define TSRM_ADDR_RMT_HIGH_UP     8'h07
`define TSRM_ADDR_RMT_LOW_UP      8'h08
`define TSRM_ADDR_CONFIG_ALIAS    8'h09
`define TSRM_ADDR_CONV_ALIAS      8'h0A
`define TSRM_ADDR_LHIGH_ALIAS     8'h0B
`define TSRM_ADDR_RHIGH_ALIAS     8'h0D
`define TSRM_ADDR_RLOW_ALIAS      8'h0E
`define TSRM_ADDR_ONE_SHOT        8'h0F
`define TSRM_ADDR_RMT_S_LO        8'h10
`define TSRM_ADDR_OFFSET_UP       8'h11
`define TSRM_ADDR_OFFSET_LO       8'h12
`define TSRM_ADDR_RMT_HIGH_LO     8'h13
`define TSRM_ADDR_RMT_LOW_LO      8'h14
`define TSRM_ADDR_ALERT_MASK      8'h16
`define TSRM_ADDR_CRIT_LIMIT      8'h19
`define TSRM_ADDR_CRIT_HYST       8'h21
`define TSRM_ADDR_RMT_U_HI        8'h31
`define TSRM_ADDR_RMT_U_LO        8'h32
`define TSRM_ADDR_POR_FLAGS       8'h33

// ****************************************************************
// Reset values.
// ****************************************************************
`define TSRM_RST_CONFIG           8'h00
`define TSRM_RST_CONV_RATE        8'h80
`define TSRM_RST_LOCAL_HIGH       8'h46
`define TSRM_RST_RMT_HIGH_UP      8'h69
`define TSRM_RST_RMT_LOW_UP       8'h00
`define TSRM_RST_OFFSET_UP        8'h00
`define TSRM_RST_OFFSET_LO        8'h00
`define TSRM_RST_RMT_HIGH_LO      8'h00
`define TSRM_RST_RMT_LOW_LO       8'h00
`define TSRM_RST_ALERT_MASK       8'hA4
`define TSRM_RST_CRIT_LIMIT       8'h6E
`define TSRM_RST_CRIT_HYST        8'h0A
`define TSRM_RESERVED_VALUE       8'h00

// ****************************************************************
// Bit masks, forced-one patterns and bit positions.
// ****************************************************************
`define TSRM_CONFIG_WMASK         8'hE7
`define TSRM_CONV_WMASK           8'h0F
`define TSRM_CONV_FIXED           8'h80
`define TSRM_FRAC_WMASK           8'hE0
`define TSRM_MASK_WMASK           8'h5B
`define TSRM_MASK_FIXED           8'hA4
`define TSRM_ALERT_WMASK          8'hDF
`define TSRM_FINE_WMASK           8'hF8
`define TSRM_POR_NOT_READY_BIT    7
`define TSRM_CONFIG_STANDBY_BIT   6

`endif

/* hdl/tsrm_pkg.sv */
package tsrm_pkg;

    // Remote-reading filter selector codes.
    typedef enum logic [1:0] {
        TSRM_FILT_NONE     = 2'b00,
        TSRM_FILT_STANDARD = 2'b01,
        TSRM_FILT_RESERVED = 2'b10,
        TSRM_FILT_ENHANCED = 2'b11
    } tsrm_filter_type;

endpackage : tsrm_pkg

/* hdl/tsrm_wr_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface tsrm_wr_if;
    logic       we;
    logic [7:0] wdata;
    logic [7:0] value;
    modport bank (input we, input wdata, output value);
    modport ctrl (output we, output wdata, input value);
endinterface : tsrm_wr_if

`default_nettype wire

/* hdl/tsrm_reg8.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tsrm_consts.svh"

module tsrm_reg8 #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WMASK   = 8'hFF,
    parameter logic [7:0] FIXED   = 8'h00
) (
    // Clock and reset.
    input  wire logic  clk,
    input  wire logic  rst,
    // Write port and stored value.
    tsrm_wr_if.bank    port
);

    logic [7:0] data_r;
    logic [7:0] data_nxt;

    always_comb begin
        data_nxt = data_r;
        if (port.we) begin
            data_nxt = (port.wdata & WMASK) | FIXED;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            data_r <= RST_VAL;
        end else begin
            data_r <= data_nxt;
        end
    end

    assign port.value = (data_r & WMASK) | FIXED;

endmodule : tsrm_reg8

`default_nettype wire

/* hdl/tsrm_register_bank.sv */
// Overview of operation
// - Addresses 09h, 0Ah, 0Bh share storage with 03h, 04h, 05h.
// - Addresses 0Dh, 0Eh share storage with 07h, 08h.
// - Reserved locations are read-only and return 00h.
// - Local reading at 00h is 8-bit two's complement, 1 degree steps.
// - With filter or fine bit, 10h carries five fraction bits, low three zero.
// - One-shot write starts one conversion in standby; reads return zero.
// - Filter selector: 00 none, 01 standard, 11 enhanced, 10 reserved.
`timescale 1ns/1ps
`default_nettype none
`include "tsrm_consts.svh"

module tsrm_register_bank (
    // Clock and reset.
    input  wire logic       SYS_CLK,
    input  wire logic       RST,
    // Register access from the serial interface.
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_WDATA,
    output var  logic [7:0] REG_RDATA,
    // Measurement results.
    input  wire logic [7:0] LOCAL_READING_BITS,
    input  wire logic [12:0] REMOTE_SIGNED_BITS,
    input  wire logic [12:0] REMOTE_UNSIGNED_BITS,
    input  wire logic [7:0] ALERT_STATUS,
    input  wire logic       NOT_READY,
    // Filter and fine-resolution settings held elsewhere.
    input  wire logic [1:0] REMOTE_FILTER_SELECT,
    input  wire logic       FINE_LSB_FORCE,
    // Configuration outputs.
    output var  logic [7:0] CONFIG_OUT,
    output var  logic [3:0] CONV_RATE_OUT,
    output var  logic [7:0] LOCAL_HIGH_OUT,
    output var  logic [10:0] RMT_HIGH_OUT,
    output var  logic [10:0] RMT_LOW_OUT,
    output var  logic [10:0] RMT_OFFSET_OUT,
    output var  logic [7:0] ALERT_MASK_OUT,
    output var  logic [7:0] CRIT_LIMIT_OUT,
    output var  logic [7:0] CRIT_HYST_OUT,
    output var  logic       FILTER_ACTIVE,
    output var  logic       ONE_SHOT_START
);

    // ****************************************************************
    // Write decode.
    // ****************************************************************
    localparam int NREG = 11;

    tsrm_wr_if wr[NREG] ();

    logic [NREG-1:0] hit;
    logic            os_nxt;
    logic            os_r;
    logic [7:0]      rdata_nxt;
    logic [7:0]      rdata_r;

    // Each mirror address selects the same storage slot as its primary address.
    always_comb begin
        hit = '0;
        unique case (REG_ADDR)
            `TSRM_ADDR_CONFIG, `TSRM_ADDR_CONFIG_ALIAS:     hit[0]  = 1'b1;
            `TSRM_ADDR_CONV_RATE, `TSRM_ADDR_CONV_ALIAS:    hit[1]  = 1'b1;
            `TSRM_ADDR_LOCAL_HIGH, `TSRM_ADDR_LHIGH_ALIAS:  hit[2]  = 1'b1;
            `TSRM_ADDR_RMT_HIGH_UP, `TSRM_ADDR_RHIGH_ALIAS: hit[3]  = 1'b1;
            `TSRM_ADDR_RMT_LOW_UP, `TSRM_ADDR_RLOW_ALIAS:   hit[4]  = 1'b1;
            `TSRM_ADDR_OFFSET_UP:                           hit[5]  = 1'b1;
            `TSRM_ADDR_OFFSET_LO:                           hit[6]  = 1'b1;
            `TSRM_ADDR_RMT_HIGH_LO:                         hit[7]  = 1'b1;
            `TSRM_ADDR_RMT_LOW_LO:                          hit[8]  = 1'b1;
            `TSRM_ADDR_ALERT_MASK:                          hit[9]  = 1'b1;
            `TSRM_ADDR_CRIT_LIMIT:                          hit[10] = 1'b1;
            default:                                        hit     = '0;
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_we
            assign wr[gi].we    = REG_WR & hit[gi];
            assign wr[gi].wdata = REG_WDATA;
        end
    endgenerate

    // ****************************************************************
    // Storage.
    // ****************************************************************
    tsrm_reg8 #(.RST_VAL(`TSRM_RST_CONFIG), .WMASK(`TSRM_CONFIG_WMASK), .FIXED(8'h00))
        u_config (.clk(SYS_CLK), .rst(RST), .port(wr[0]));
    tsrm_reg8 #(.RST_VAL(`TSRM_RST_CONV_RATE), .WMASK(`TSRM_CONV_WMASK), .FIXED(8'h00))
        u_conv (.clk(SYS_CLK), .rst(RST), .port(wr[1]));
    tsrm_reg8 #(.RST_VAL(`TSRM_RST_LOCAL_HIGH), .WMASK(8'hFF), .FIXED(8'h00))
        u_lhigh (.clk(SYS_CLK), .rst(RST), .port(wr[2]));
    tsrm_reg8 #(.RST_VAL(`TSRM_RST_RMT_HIGH_UP), .WMASK(8'hFF), .FIXED(8'h00))
        u_rhigh_up (.clk(SYS_CLK), .rst(RST), .port(wr[3]));
    tsrm_reg8 #(.RST_VAL(`TSRM_RST_RMT_LOW_UP), .WMASK(8'hFF), .FIXED(8'h00))
        u_rlow_up (.clk(SYS_CLK), .rst(RST), .port(wr[4]));
    tsrm_reg8 #(.RST_VAL(`TSRM_RST_OFFSET_UP), .WMASK(8'hFF), .FIXED(8'h00))
        u_off_up (.clk(SYS_CLK), .rst(RST), .port(wr[5]));
    tsrm_reg8 #(.RST_VAL(`TSRM_RST_OFFSET_LO), .WMASK(`TSRM_FRAC_WMASK), .FIXED(8'h00))
        u_off_lo (.clk(SYS_CLK), .rst(RST), .port(wr[6]));
    tsrm_reg8 #(.RST_VAL(`TSRM_RST_RMT_HIGH_LO), .WMASK(`TSRM_FRAC_WMASK), .FIXED(8'h00))
        u_rhigh_lo (.clk(SYS_CLK), .rst(RST), .port(wr[7]));
    tsrm_reg8 #(.RST_VAL(`TSRM_RST_RMT_LOW_LO), .WMASK(`TSRM_FRAC_WMASK), .FIXED(8'h00))
        u_rlow_lo (.clk(SYS_CLK), .rst(RST), .port(wr[8]));
    tsrm_reg8 #(.RST_VAL(`TSRM_RST_ALERT_MASK), .WMASK(`TSRM_MASK_WMASK), .FIXED(`TSRM_MASK_FIXED))
        u_mask (.clk(SYS_CLK), .rst(RST), .port(wr[9]));
    tsrm_reg8 #(.RST_VAL(`TSRM_RST_CRIT_LIMIT), .WMASK(8'hFF), .FIXED(8'h00))
        u_crit (.clk(SYS_CLK), .rst(RST), .port(wr[10]));

    // The hysteresis register sits outside the array so its sign bit stays zero.
    logic [7:0] hyst_r;
    logic [7:0] hyst_nxt;

    always_comb begin
        hyst_nxt = hyst_r;
        if (REG_WR && (REG_ADDR == `TSRM_ADDR_CRIT_HYST)) begin
            hyst_nxt = {1'b0, REG_WDATA[6:0]};
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            hyst_r <= `TSRM_RST_CRIT_HYST;
        end else begin
            hyst_r <= hyst_nxt;
        end
    end

    // ****************************************************************
    // Filter selection and fine fraction.
    // ****************************************************************
    tsrm_pkg::tsrm_filter_type filt;
    logic                      fine_en;
    logic [7:0]                s_lo;
    logic [7:0]                u_lo;

    always_comb begin
        filt = tsrm_pkg::tsrm_filter_type'(REMOTE_FILTER_SELECT);
        case (filt)
            tsrm_pkg::TSRM_FILT_STANDARD: FILTER_ACTIVE = 1'b1;
            tsrm_pkg::TSRM_FILT_ENHANCED: FILTER_ACTIVE = 1'b1;
            default:                      FILTER_ACTIVE = 1'b0;
        endcase
        fine_en = FILTER_ACTIVE | FINE_LSB_FORCE;
        // Fraction bits below 1/8 degree are hidden unless fine resolution applies.
        s_lo = {REMOTE_SIGNED_BITS[4:0], 3'b000} & (fine_en ? `TSRM_FINE_WMASK : `TSRM_FRAC_WMASK);
        u_lo = {REMOTE_UNSIGNED_BITS[4:0], 3'b000} & (fine_en ? `TSRM_FINE_WMASK : `TSRM_FRAC_WMASK);
    end

    // ****************************************************************
    // One-shot and read mux.
    // ****************************************************************
    // The start pulse is raised only while the configuration holds the standby bit.
    always_comb begin
        os_nxt = REG_WR && (REG_ADDR == `TSRM_ADDR_ONE_SHOT) && wr[0].value[`TSRM_CONFIG_STANDBY_BIT];
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            os_r <= 1'b0;
        end else begin
            os_r <= os_nxt;
        end
    end

    // Read data is captured on the read strobe and held until the next one.
    always_comb begin
        rdata_nxt = rdata_r;
        if (REG_RD) begin
            case (REG_ADDR)
                `TSRM_ADDR_LOCAL_TEMP:  rdata_nxt = LOCAL_READING_BITS;
                `TSRM_ADDR_RMT_S_HI:    rdata_nxt = REMOTE_SIGNED_BITS[12:5];
                `TSRM_ADDR_ALERT_FLAGS: rdata_nxt = ALERT_STATUS & `TSRM_ALERT_WMASK;
                `TSRM_ADDR_CONFIG, `TSRM_ADDR_CONFIG_ALIAS:     rdata_nxt = wr[0].value;
                `TSRM_ADDR_CONV_RATE, `TSRM_ADDR_CONV_ALIAS:    rdata_nxt = wr[1].value;
                `TSRM_ADDR_LOCAL_HIGH, `TSRM_ADDR_LHIGH_ALIAS:  rdata_nxt = wr[2].value;
                `TSRM_ADDR_RMT_HIGH_UP, `TSRM_ADDR_RHIGH_ALIAS: rdata_nxt = wr[3].value;
                `TSRM_ADDR_RMT_LOW_UP, `TSRM_ADDR_RLOW_ALIAS:   rdata_nxt = wr[4].value;
                `TSRM_ADDR_ONE_SHOT:    rdata_nxt = 8'h00;
                `TSRM_ADDR_RMT_S_LO:    rdata_nxt = s_lo;
                `TSRM_ADDR_OFFSET_UP:   rdata_nxt = wr[5].value;
                `TSRM_ADDR_OFFSET_LO:   rdata_nxt = wr[6].value;
                `TSRM_ADDR_RMT_HIGH_LO: rdata_nxt = wr[7].value;
                `TSRM_ADDR_RMT_LOW_LO:  rdata_nxt = wr[8].value;
                `TSRM_ADDR_ALERT_MASK:  rdata_nxt = wr[9].value;
                `TSRM_ADDR_CRIT_LIMIT:  rdata_nxt = wr[10].value;
                `TSRM_ADDR_CRIT_HYST:   rdata_nxt = hyst_r;
                `TSRM_ADDR_RMT_U_HI:    rdata_nxt = REMOTE_UNSIGNED_BITS[12:5];
                `TSRM_ADDR_RMT_U_LO:    rdata_nxt = u_lo;
                `TSRM_ADDR_POR_FLAGS:   rdata_nxt = {NOT_READY, 7'h00};
                default:                rdata_nxt = `TSRM_RESERVED_VALUE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign REG_RDATA      = rdata_r;
    assign ONE_SHOT_START = os_r;
    assign CONFIG_OUT     = wr[0].value;
    assign CONV_RATE_OUT  = wr[1].value[3:0];
    assign LOCAL_HIGH_OUT = wr[2].value;
    // The 11-bit limits pair the upper byte with the top three bits of the lower byte.
    assign RMT_HIGH_OUT   = {wr[3].value, wr[7].value[7:5]};
    assign RMT_LOW_OUT    = {wr[4].value, wr[8].value[7:5]};
    assign RMT_OFFSET_OUT = {wr[5].value, wr[6].value[7:5]};
    assign ALERT_MASK_OUT = wr[9].value;
    assign CRIT_LIMIT_OUT = wr[10].value;
    assign CRIT_HYST_OUT  = hyst_r;

endmodule : tsrm_register_bank

`default_nettype wire

/* tb/tsrm_register_bank_sva.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Port checker for the register bank.
// ****************************************************************
module tsrm_register_bank_sva (
    // Clock and reset.
    input wire logic        SYS_CLK,
    input wire logic        RST,
    // Register access.
    input wire logic [7:0]  REG_ADDR,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_WDATA,
    input wire logic [7:0]  REG_RDATA,
    // Readings and settings.
    input wire logic [7:0]  LOCAL_READING_BITS,
    input wire logic [12:0] REMOTE_SIGNED_BITS,
    input wire logic [1:0]  REMOTE_FILTER_SELECT,
    // Outputs.
    input wire logic [7:0]  CONFIG_OUT,
    input wire logic [3:0]  CONV_RATE_OUT,
    input wire logic [7:0]  LOCAL_HIGH_OUT,
    input wire logic [10:0] RMT_HIGH_OUT,
    input wire logic [10:0] RMT_LOW_OUT,
    input wire logic        FILTER_ACTIVE,
    input wire logic        ONE_SHOT_START
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    chk_cfg_alias: assert property (
        REG_WR && REG_ADDR inside {8'h03, 8'h09} |=> CONFIG_OUT == ($past(REG_WDATA) & 8'hE7))
        else $error("config write mismatch");
    chk_rate_alias: assert property (
        REG_WR && REG_ADDR inside {8'h04, 8'h0A} |=> {4'h0, CONV_RATE_OUT} == ($past(REG_WDATA) & 8'h0F))
        else $error("rate write mismatch");
    chk_lhigh_alias: assert property (
        REG_WR && REG_ADDR inside {8'h05, 8'h0B} |=> LOCAL_HIGH_OUT == $past(REG_WDATA))
        else $error("local limit write mismatch");
    chk_rhigh_alias: assert property (
        REG_WR && REG_ADDR inside {8'h07, 8'h0D} |=> RMT_HIGH_OUT[10:3] == $past(REG_WDATA))
        else $error("remote high write mismatch");
    chk_rlow_alias: assert property (
        REG_WR && REG_ADDR inside {8'h08, 8'h0E} |=> RMT_LOW_OUT[10:3] == $past(REG_WDATA))
        else $error("remote low write mismatch");
    chk_reserved_zero: assert property (
        REG_RD && REG_ADDR inside {8'h06, 8'h0C, 8'h15, [8'h17:8'h18], [8'h1A:8'h20], [8'h22:8'h30],
        [8'h34:8'h44]} |=> REG_RDATA == 8'h00) else $error("reserved read not zero");
    chk_local_read: assert property (
        REG_RD && REG_ADDR == 8'h00 ##1 $stable(LOCAL_READING_BITS) |-> REG_RDATA == LOCAL_READING_BITS)
        else $error("local reading mismatch");
    chk_frac_read: assert property (
        REG_RD && REG_ADDR == 8'h10 && FILTER_ACTIVE ##1 $stable(REMOTE_SIGNED_BITS)
        |-> REG_RDATA == {REMOTE_SIGNED_BITS[4:0], 3'h0}) else $error("fraction read mismatch");
    chk_filter_code: assert property (
        FILTER_ACTIVE == (REMOTE_FILTER_SELECT inside {tsrm_pkg::TSRM_FILT_STANDARD,
        tsrm_pkg::TSRM_FILT_ENHANCED})) else $error("filter decode mismatch");
    chk_shot_pulse: assert property (
        REG_WR && REG_ADDR == 8'h0F && CONFIG_OUT[6] |=> ONE_SHOT_START) else $error("one-shot missing");
    chk_shot_cause: assert property (
        $rose(ONE_SHOT_START) |-> $past(REG_WR) && $past(REG_ADDR) == 8'h0F
        && ($past(CONFIG_OUT) & 8'h40) != 8'h00) else $error("one-shot without cause");
    chk_shot_read: assert property (
        REG_RD && REG_ADDR == 8'h0F |=> REG_RDATA == 8'h00) else $error("one-shot read not zero");
endmodule : tsrm_register_bank_sva

bind tsrm_register_bank tsrm_register_bank_sva tsrm_register_bank_sva_i (.SYS_CLK, .RST, .REG_ADDR,
    .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA, .LOCAL_READING_BITS, .REMOTE_SIGNED_BITS,
    .REMOTE_FILTER_SELECT, .CONFIG_OUT, .CONV_RATE_OUT, .LOCAL_HIGH_OUT, .RMT_HIGH_OUT, .RMT_LOW_OUT,
    .FILTER_ACTIVE, .ONE_SHOT_START);

`default_nettype wire

/* tb/tsrm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Host issuing one-cycle register strobes.
// ****************************************************************
module tsrm_host_model (
    // Clock.
    input  wire logic       clk,
    // Register access.
    output logic [7:0]      addr,
    output logic            wr,
    output logic            rd,
    output logic [7:0]      wdata,
    input  wire logic [7:0] rdata
);
    initial begin
        addr = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
    end

    // Any address is driven as given; the testbench also writes reserved locations up to 44h.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        wdata = ~d;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask : read_reg
endmodule : tsrm_host_model

`default_nettype wire

/* tb/tsrm_register_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define TSRM_CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); end end

module tsrm_register_bank_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, cfg_o, d, mask_o, crit_o, hyst_o;
    logic reg_wr, reg_rd, filt_act, shot, fine = 1'b0, not_ready = 1'b1;
    logic [7:0] local_bits = 8'h00, alert = 8'hFF;
    logic [12:0] rs_bits = {8'hC9, 5'b10111}, ru_bits = {8'hA5, 5'b01101};
    logic [1:0] filt = 2'b00;
    logic [10:0] offs_o;
    int bad_count = 0, total_checks = 0, cycles = 0;
    logic [7:0] ta[12] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h19, 8'h21};
    logic [7:0] te[12] = '{8'h00, 8'h00, 8'h46, 8'h69, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA4, 8'h6E, 8'h0A};
    logic [7:0] wa[8] = '{8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h12, 8'h16, 8'h21};
    logic [7:0] ra[8] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h12, 8'h16, 8'h21};
    logic [7:0] wd[8] = '{8'hFF, 8'hFF, 8'h9C, 8'h5A, 8'hC3, 8'hFF, 8'h00, 8'hFF};
    logic [7:0] we[8] = '{8'hE7, 8'h0F, 8'h9C, 8'h5A, 8'hC3, 8'hE0, 8'hA4, 8'h7F};
    logic [7:0] rv[12] = '{8'h06, 8'h0C, 8'h15, 8'h17, 8'h18, 8'h1A, 8'h20, 8'h22, 8'h2F, 8'h30, 8'h34, 8'h44};

    always #12.5 sys_clk = ~sys_clk;

    tsrm_host_model tsrm_host_model_i (.clk(sys_clk), .addr(reg_addr), .wr(reg_wr), .rd(reg_rd),
        .wdata(reg_wdata), .rdata(reg_rdata));

    tsrm_register_bank tsrm_register_bank_i (.SYS_CLK(sys_clk), .RST(rst), .REG_ADDR(reg_addr),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .LOCAL_READING_BITS(local_bits), .REMOTE_SIGNED_BITS(rs_bits), .REMOTE_UNSIGNED_BITS(ru_bits),
        .ALERT_STATUS(alert), .NOT_READY(not_ready), .REMOTE_FILTER_SELECT(filt), .FINE_LSB_FORCE(fine),
        .CONFIG_OUT(cfg_o), .CONV_RATE_OUT(), .LOCAL_HIGH_OUT(), .RMT_HIGH_OUT(), .RMT_LOW_OUT(),
        .RMT_OFFSET_OUT(offs_o), .ALERT_MASK_OUT(mask_o), .CRIT_LIMIT_OUT(crit_o), .CRIT_HYST_OUT(hyst_o),
        .FILTER_ACTIVE(filt_act), .ONE_SHOT_START(shot));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        tsrm_host_model_i.read_reg(a, d);
        `TSRM_CHK($sformatf("read of %h", a), e, d)
    endtask : rd_chk

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            finish_test();
        end
    end

    initial begin
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        for (int i = 0; i < 12; i++) begin
            rd_chk(ta[i], te[i]);
        end
        rd_chk(8'h02, 8'hDF);
        rd_chk(8'h33, 8'h80);
        for (int i = 0; i < 8; i++) begin
            tsrm_host_model_i.write_reg(wa[i], wd[i]);
            rd_chk(ra[i], we[i]);
            rd_chk(wa[i], we[i]);
        end
        `TSRM_CHK("alert mask out", 8'hA4, mask_o)
        `TSRM_CHK("hysteresis out", 8'h7F, hyst_o)
        `TSRM_CHK("critical limit out", 8'h6E, crit_o)
        tsrm_host_model_i.write_reg(8'h19, 8'h96);
        `TSRM_CHK("critical limit out", 8'h96, crit_o)
        rd_chk(8'h19, 8'h96);
        tsrm_host_model_i.write_reg(8'h11, 8'h81);
        `TSRM_CHK("offset", 11'h40F, offs_o)
        for (int i = 0; i < 12; i++) begin
            tsrm_host_model_i.write_reg(rv[i], 8'hFF);
            rd_chk(rv[i], 8'h00);
        end
        local_bits = 8'hC9;
        rd_chk(8'h00, 8'hC9);
        local_bits = 8'h7D;
        rd_chk(8'h00, 8'h7D);
        rd_chk(8'h01, 8'hC9);
        rd_chk(8'h31, 8'hA5);
        for (int c = 0; c < 5; c++) begin
            filt = c[1:0];
            fine = (c == 4);
            rd_chk(8'h10, (c == 0 || c == 2) ? 8'hA0 : 8'hB8);
            rd_chk(8'h32, (c == 0 || c == 2) ? 8'h60 : 8'h68);
            `TSRM_CHK("filter active", 1'(c == 1 || c == 3), filt_act)
        end
        tsrm_host_model_i.write_reg(8'h03, 8'h00);
        tsrm_host_model_i.write_reg(8'h0F, 8'h5A);
        `TSRM_CHK("one-shot outside standby", 1'b0, shot)
        tsrm_host_model_i.write_reg(8'h09, 8'h40);
        `TSRM_CHK("config out", 8'h40, cfg_o)
        tsrm_host_model_i.write_reg(8'h0F, 8'hFF);
        `TSRM_CHK("one-shot pulse", 1'b1, shot)
        @(negedge sys_clk);
        `TSRM_CHK("one-shot end", 1'b0, shot)
        rd_chk(8'h0F, 8'h00);
        finish_test();
    end
endmodule : tsrm_register_bank_tb

`default_nettype wire
